// >>> rcl_calendar_block.sv
// Contract
// R1: Writing the time window high byte steps its pointer down, stopping at zero.
// R2: Time pointer selects minutes/seconds, weekday/hours, month/day, or year.
// R3: Writing the alarm window high byte steps its pointer down, stopping at zero.
// R4: Alarm pointer selects alarm time pairs or power control window settings.
// R5: Reading either byte of either window also steps that window's pointer down.
// R6: Time value writes are ignored unless timer write enable is set.
// R7: Timer write enable sets only right after key bytes 55h then AAh.
// R8: Software keeps timer write enable clear except while updating time.
// R9: Two-bit source field picks crystal, internal oscillator, 50 Hz or 60 Hz.
// R10: Counting is correct for each of the four supported source rates.
// R11: Hours, minutes and seconds kept, hours in 24-hour form wrapping after 23.
// R12: Software can see which half of the current second is running.
// R13: Weekday, day, month and two-digit year kept with leap years 2000-2099.
// R14: All time, date and alarm values are held in BCD.
// R15: Alarm masks from every half second up to once a year.
// R16: Alarm repeat counter decrements on each alarm occurrence.
// R17: Chime keeps the alarm repeating even when the counter reaches zero.
// R18: Drift calibration is applied once every 15 seconds; here only with the crystal or internal oscillator source, never 50 Hz or 60 Hz.
// R19: Calibration range covers source error up to 260 ppm.
// R20: Power control output enables external circuits without processor help.
// R21: Signed 8-bit trim adds or removes four source pulses per step each minute.
// R22: Alarm enable clears itself after an event with counter zero and no chime.
// R23: Counter wraps zero to FFh only with chime, else holds at zero.
// R24: Day count follows month length, February 29 only in years divisible by four.
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rcl_calendar_block
   import rcl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic secondary_crystal_osc_in,
   input wire logic internal_low_power_osc_in,
   input wire logic line_in,
   output logic rtc_out,
   output logic rtc_out_en,
   output logic pwr_ctl_out,
   output logic alarm_pulse_out
);

   rcl_core_type s_ff;
   rcl_core_type nxt_s;
   rcl_tick_if tk ();

   rcl_prescaler u_pre (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .secondary_crystal_osc_in(secondary_crystal_osc_in),
      .internal_low_power_osc_in(internal_low_power_osc_in),
      .line_in(line_in),
      .tk(tk)
   );

   // BCD increment with wrap from top back to bottom.
   function automatic logic [7:0] bcd_inc(input logic [7:0] v,
      input logic [7:0] top, input logic [7:0] bot);
      if (v >= top)
      begin
         return bot;
      end
      else if (v[3:0] == 4'h9)
      begin
         return {v[7:4] + 4'h1, 4'h0}; // R14
      end
      return v + 8'h01;
   endfunction

   function automatic logic is_leap(input logic [7:0] yr);
      if (yr[4])
      begin
         return (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6); // R13 R24
      end
      return (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] month_len(input logic [7:0] mo,
      input logic [7:0] yr);
      case (mo)
         8'h02: return is_leap(yr) ? 8'h29 : 8'h28; // R24
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default: return 8'h31;
      endcase
   endfunction

   always_comb
   begin
      logic [15:0] rd;
      logic hit;
      logic fire;
      logic acc;
      logic sec_eq;
      logic min_eq;
      logic tick_ok;
      logic [7:0] win;
      rd = 16'h0000;
      hit = 1'b0;
      fire = 1'b0;
      tick_ok = 1'b0;
      win = 8'h00;
      acc = !s_ff.wait_n && (avs_read || avs_write);
      sec_eq = s_ff.sec == s_ff.asec;
      min_eq = s_ff.min == s_ff.amin;
      nxt_s = s_ff;
      nxt_s.resync = 1'b0;
      nxt_s.alm_pulse = 1'b0;
      nxt_s.chk = tk.half_pulse;

      // Calendar advance at the end of each whole second.
      if (tk.half_pulse && !tk.halfsec)
      begin
         nxt_s.sec = bcd_inc(s_ff.sec, 8'h59, 8'h00); // R11
         if (s_ff.sec >= 8'h59)
         begin
            nxt_s.min = bcd_inc(s_ff.min, 8'h59, 8'h00); // R11
            if (s_ff.min >= 8'h59)
            begin
               nxt_s.hour = bcd_inc(s_ff.hour, 8'h23, 8'h00); // R11
               if (s_ff.hour >= 8'h23)
               begin
                  nxt_s.wday = bcd_inc(s_ff.wday, 8'h06, 8'h00); // R13
                  nxt_s.day = bcd_inc(s_ff.day,
                     month_len(s_ff.mon, s_ff.year), 8'h01); // R24
                  if (s_ff.day >= month_len(s_ff.mon, s_ff.year))
                  begin
                     nxt_s.mon = bcd_inc(s_ff.mon, 8'h12, 8'h01); // R13
                     if (s_ff.mon >= 8'h12)
                     begin
                        nxt_s.year = bcd_inc(s_ff.year, 8'h99, 8'h00);
                     end
                  end
               end
            end
         end
      end

      // Alarm compare one cycle after the calendar has advanced.
      unique case (s_ff.mask) // R15
         4'h1: hit = 1'b1;
         4'h2: hit = s_ff.sec[3:0] == s_ff.asec[3:0];
         4'h3: hit = sec_eq;
         4'h4: hit = sec_eq && s_ff.min[3:0] == s_ff.amin[3:0];
         4'h5: hit = sec_eq && min_eq;
         4'h6: hit = sec_eq && min_eq && s_ff.hour == s_ff.ahour;
         4'h7: hit = sec_eq && min_eq && s_ff.hour == s_ff.ahour
            && s_ff.wday == s_ff.awday;
         4'h8: hit = sec_eq && min_eq && s_ff.hour == s_ff.ahour
            && s_ff.day == s_ff.aday;
         4'h9: hit = sec_eq && min_eq && s_ff.hour == s_ff.ahour
            && s_ff.day == s_ff.aday && s_ff.mon == s_ff.amon;
         default: hit = 1'b0;
      endcase
      fire = s_ff.chk && s_ff.alen
         && (s_ff.mask == 4'h0 || (!tk.halfsec && hit)); // R15
      if (fire)
      begin
         nxt_s.alm_pulse = 1'b1;
         if (s_ff.rpt == 8'h00)
         begin
            if (s_ff.chime)
            begin
               nxt_s.rpt = RPT_WRAP; // R17 R23
            end
            else
            begin
               nxt_s.alen = 1'b0; // R22
            end
         end
         else
         begin
            nxt_s.rpt = s_ff.rpt - 8'h01; // R16 R23
         end
         if (s_ff.pwcen)
         begin
            nxt_s.pwr = PWR_STAB; // R20
            nxt_s.pwr_cnt = 8'h00;
            nxt_s.pwr_div = 1'b0;
         end
      end

      // Power control: stability window then sample window on source ticks.
      if (s_ff.pwr != PWR_IDLE && tk.src_edge)
      begin
         nxt_s.pwr_div = ~s_ff.pwr_div;
         if (s_ff.pwr == PWR_STAB)
         begin
            tick_ok = !s_ff.cpre || s_ff.pwr_div;
            win = s_ff.stab;
         end
         else
         begin
            tick_ok = !s_ff.spre || s_ff.pwr_div;
            win = s_ff.samp;
         end
         if (tick_ok)
         begin
            if (s_ff.pwr_cnt >= win)
            begin
               nxt_s.pwr_cnt = 8'h00;
               nxt_s.pwr = (s_ff.pwr == PWR_STAB) ? PWR_SAMP : PWR_IDLE;
            end
            else
            begin
               nxt_s.pwr_cnt = s_ff.pwr_cnt + 8'h01; // R20
            end
         end
      end
      if (!s_ff.pwcen)
      begin
         nxt_s.pwr = PWR_IDLE;
      end
      nxt_s.pwr_out = (s_ff.pwcen && s_ff.pwr != PWR_IDLE)
         ? s_ff.pol : ~s_ff.pol; // R20

      // Read data mux.
      unique case (avs_address)
         IDX_CFG: rd = {s_ff.en, 1'b0, s_ff.wren, tk.halfsec, tk.halfsec,
            s_ff.oe, s_ff.tptr, s_ff.cal}; // R12
         IDX_PWC: rd = {s_ff.pwcen, s_ff.pol, s_ff.cpre, s_ff.spre,
            s_ff.csel, s_ff.osel, 8'h00};
         IDX_ALCFG: rd = {s_ff.alen, s_ff.chime, s_ff.mask, s_ff.aptr,
            s_ff.rpt};
         IDX_TVAL:
         begin
            unique case (s_ff.tptr) // R2
               2'h0: rd = {s_ff.min, s_ff.sec};
               2'h1: rd = {s_ff.wday, s_ff.hour};
               2'h2: rd = {s_ff.mon, s_ff.day};
               2'h3: rd = {8'h00, s_ff.year};
            endcase
         end
         IDX_AVAL:
         begin
            unique case (s_ff.aptr) // R4
               2'h0: rd = {s_ff.amin, s_ff.asec};
               2'h1: rd = {s_ff.awday, s_ff.ahour};
               2'h2: rd = {s_ff.amon, s_ff.aday};
               2'h3: rd = {s_ff.stab, s_ff.samp};
            endcase
         end
         default: rd = 16'h0000;
      endcase

      // Bus handshake: one wait cycle, then the accept cycle.
      if (s_ff.wait_n)
      begin
         if (avs_read || avs_write)
         begin
            nxt_s.wait_n = 1'b0;
            nxt_s.rdata = avs_read ? rd : 16'h0000;
         end
      end
      else
      begin
         nxt_s.wait_n = 1'b1;
      end

      if (acc)
      begin
         if (s_ff.key == KEY_OPEN)
         begin
            nxt_s.key = KEY_IDLE; // R7
         end
         if (avs_read && avs_address == IDX_TVAL && s_ff.tptr != 2'h0)
         begin
            nxt_s.tptr = s_ff.tptr - 2'h1; // R5
         end
         if (avs_read && avs_address == IDX_AVAL && s_ff.aptr != 2'h0)
         begin
            nxt_s.aptr = s_ff.aptr - 2'h1; // R5
         end
         if (avs_write)
         begin
            unique case (avs_address)
               IDX_KEY:
               begin
                  if (avs_byteenable[0])
                  begin
                     if (avs_writedata[7:0] == KEY_FIRST)
                     begin
                        nxt_s.key = KEY_HALF; // R7
                     end
                     else if (avs_writedata[7:0] == KEY_SECOND
                        && s_ff.key == KEY_HALF)
                     begin
                        nxt_s.key = KEY_OPEN; // R7
                     end
                     else
                     begin
                        nxt_s.key = KEY_IDLE;
                     end
                  end
               end
               IDX_CFG:
               begin
                  if (avs_byteenable[1])
                  begin
                     if (!avs_writedata[CFG_WREN] || s_ff.key == KEY_OPEN
                        || s_ff.wren)
                     begin
                        nxt_s.wren = avs_writedata[CFG_WREN]; // R7
                     end
                     if (s_ff.wren)
                     begin
                        nxt_s.en = avs_writedata[CFG_EN]; // R6
                     end
                     nxt_s.oe = avs_writedata[CFG_OE];
                     nxt_s.tptr = avs_writedata[CFG_PTR +: 2];
                  end
                  if (avs_byteenable[0])
                  begin
                     nxt_s.cal = avs_writedata[7:0]; // R21
                  end
               end
               IDX_PWC:
               begin
                  if (avs_byteenable[1])
                  begin
                     nxt_s.pwcen = avs_writedata[PWC_EN];
                     nxt_s.pol = avs_writedata[PWC_POL];
                     nxt_s.cpre = avs_writedata[PWC_CPRE];
                     nxt_s.spre = avs_writedata[PWC_SPRE];
                     nxt_s.csel = avs_writedata[PWC_CSEL +: 2]; // R9
                     nxt_s.osel = avs_writedata[PWC_OSEL +: 2];
                  end
               end
               IDX_ALCFG:
               begin
                  if (avs_byteenable[1])
                  begin
                     nxt_s.alen = avs_writedata[AL_EN];
                     nxt_s.chime = avs_writedata[AL_CHIME];
                     nxt_s.mask = avs_writedata[AL_MASK +: 4];
                     nxt_s.aptr = avs_writedata[AL_PTR +: 2];
                  end
                  if (avs_byteenable[0])
                  begin
                     nxt_s.rpt = avs_writedata[7:0];
                  end
               end
               IDX_TVAL:
               begin
                  if (s_ff.wren) // R6
                  begin
                     if (avs_byteenable[1])
                     begin
                        unique case (s_ff.tptr) // R2
                           2'h0: nxt_s.min = avs_writedata[15:8];
                           2'h1: nxt_s.wday = avs_writedata[15:8];
                           2'h2: nxt_s.mon = avs_writedata[15:8];
                           2'h3: nxt_s.min = s_ff.min;
                        endcase
                        if (s_ff.tptr != 2'h0)
                        begin
                           nxt_s.tptr = s_ff.tptr - 2'h1; // R1
                        end
                     end
                     if (avs_byteenable[0])
                     begin
                        unique case (s_ff.tptr) // R2
                           2'h0:
                           begin
                              nxt_s.sec = avs_writedata[7:0];
                              nxt_s.resync = 1'b1;
                           end
                           2'h1: nxt_s.hour = avs_writedata[7:0];
                           2'h2: nxt_s.day = avs_writedata[7:0];
                           2'h3: nxt_s.year = avs_writedata[7:0];
                        endcase
                     end
                  end
               end
               IDX_AVAL:
               begin
                  if (avs_byteenable[1])
                  begin
                     unique case (s_ff.aptr) // R4
                        2'h0: nxt_s.amin = avs_writedata[15:8];
                        2'h1: nxt_s.awday = avs_writedata[15:8];
                        2'h2: nxt_s.amon = avs_writedata[15:8];
                        2'h3: nxt_s.stab = avs_writedata[15:8];
                     endcase
                     if (s_ff.aptr != 2'h0)
                     begin
                        nxt_s.aptr = s_ff.aptr - 2'h1; // R3
                     end
                  end
                  if (avs_byteenable[0])
                  begin
                     unique case (s_ff.aptr) // R4
                        2'h0: nxt_s.asec = avs_writedata[7:0];
                        2'h1: nxt_s.ahour = avs_writedata[7:0];
                        2'h2: nxt_s.aday = avs_writedata[7:0];
                        2'h3: nxt_s.samp = avs_writedata[7:0];
                     endcase
                  end
               end
               default: nxt_s.key = nxt_s.key;
            endcase
         end
      end

      // Output pin source select.
      unique case (s_ff.osel)
         2'h0: nxt_s.out_pin = s_ff.oe && fire;
         2'h1: nxt_s.out_pin = s_ff.oe && tk.halfsec;
         2'h2: nxt_s.out_pin = s_ff.oe && tk.src_level;
         2'h3: nxt_s.out_pin = s_ff.oe && s_ff.pwr_out;
      endcase
      // A disabled module never drives the output pin.
      if (!s_ff.en)
      begin
         nxt_s.out_pin = 1'b0;
      end
      nxt_s.out_en = s_ff.oe && s_ff.en;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         s_ff <= '0;
         s_ff.wait_n <= 1'b1;
         s_ff.day <= RST_DAY;
         s_ff.mon <= RST_MON;
         s_ff.pwr_out <= 1'b1;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign tk.enable = s_ff.en;
   assign tk.resync = s_ff.resync;
   assign tk.csel = s_ff.csel;
   assign tk.cal = s_ff.cal;

   assign avs_readdata = {16'h0000, s_ff.rdata};
   assign avs_waitrequest = s_ff.wait_n;
   assign rtc_out = s_ff.out_pin;
   assign rtc_out_en = s_ff.out_en;
   assign pwr_ctl_out = s_ff.pwr_out;
   assign alarm_pulse_out = s_ff.alm_pulse;

endmodule
`default_nettype wire

// >>> rcl_pkg.sv
package rcl_pkg;

   // Word indices on the register bus; byte address is four times the index.
   localparam logic [2:0] IDX_CFG = 3'h0;
   localparam logic [2:0] IDX_PWC = 3'h1;
   localparam logic [2:0] IDX_ALCFG = 3'h2;
   localparam logic [2:0] IDX_TVAL = 3'h3;
   localparam logic [2:0] IDX_AVAL = 3'h4;
   localparam logic [2:0] IDX_KEY = 3'h5;

   // Bit positions in the configuration and calibration register.
   localparam int CFG_EN = 15;
   localparam int CFG_WREN = 13;
   localparam int CFG_OE = 10;
   localparam int CFG_PTR = 8;

   // Bit positions in the power control register.
   localparam int PWC_EN = 15;
   localparam int PWC_POL = 14;
   localparam int PWC_CPRE = 13;
   localparam int PWC_SPRE = 12;
   localparam int PWC_CSEL = 10;
   localparam int PWC_OSEL = 8;

   // Bit positions in the alarm configuration and repeat register.
   localparam int AL_EN = 15;
   localparam int AL_CHIME = 14;
   localparam int AL_MASK = 10;
   localparam int AL_PTR = 8;

   // Unlock key sequence.
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   // Counting source selections.
   localparam logic [1:0] CSEL_SECONDARY_CRYSTAL_OSC = 2'h0;
   localparam logic [1:0] CSEL_INTERNAL_LOW_POWER_OSC = 2'h1;
   localparam logic [1:0] CSEL_50HZ = 2'h2;
   localparam logic [1:0] CSEL_60HZ = 2'h3;

   // Source edges in one half second for each source.
   localparam logic [15:0] HALF_SECONDARY_CRYSTAL_OSC = 16'h4000;
   localparam logic [15:0] HALF_INTERNAL_LOW_POWER_OSC = 16'h3D09;
   localparam logic [15:0] HALF_50HZ = 16'h0019;
   localparam logic [15:0] HALF_60HZ = 16'h001E;

   // Calibration period in seconds and in half seconds.
   localparam int CAL_PERIOD_S = 15;
   localparam logic [4:0] CAL_HALVES = 5'(CAL_PERIOD_S * 2);

   // Reset values of the calendar and the repeat counter wrap value.
   localparam logic [7:0] RST_DAY = 8'h01;
   localparam logic [7:0] RST_MON = 8'h01;
   localparam logic [7:0] RPT_WRAP = 8'hFF;

   typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} rcl_key_type;
   typedef enum logic [1:0] {PWR_IDLE, PWR_STAB, PWR_SAMP} rcl_pwr_type;

   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [2:0] prev;
      logic [15:0] cnt;
      logic halfsec;
      logic half_pulse;
      logic src_edge;
      logic [4:0] cal_cnt;
   } rcl_pre_type;

   typedef struct packed {
      logic wait_n;
      logic [15:0] rdata;
      logic en;
      logic wren;
      logic oe;
      logic [1:0] tptr;
      logic [7:0] cal;
      logic pwcen;
      logic pol;
      logic cpre;
      logic spre;
      logic [1:0] csel;
      logic [1:0] osel;
      logic alen;
      logic chime;
      logic [3:0] mask;
      logic [1:0] aptr;
      logic [7:0] rpt;
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] wday;
      logic [7:0] day;
      logic [7:0] mon;
      logic [7:0] year;
      logic [7:0] asec;
      logic [7:0] amin;
      logic [7:0] ahour;
      logic [7:0] awday;
      logic [7:0] aday;
      logic [7:0] amon;
      logic [7:0] stab;
      logic [7:0] samp;
      rcl_key_type key;
      rcl_pwr_type pwr;
      logic [7:0] pwr_cnt;
      logic pwr_div;
      logic chk;
      logic resync;
      logic out_pin;
      logic out_en;
      logic pwr_out;
      logic alm_pulse;
   } rcl_core_type;

endpackage

// >>> rcl_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rcl_tick_if;
   logic enable;
   logic resync;
   logic [1:0] csel;
   logic [7:0] cal;
   logic half_pulse;
   logic halfsec;
   logic src_level;
   logic src_edge;
   modport prescaler (input enable, input resync, input csel, input cal,
      output half_pulse, output halfsec, output src_level, output src_edge);
   modport core (output enable, output resync, output csel, output cal,
      input half_pulse, input halfsec, input src_level, input src_edge);
endinterface
`default_nettype wire

// >>> rcl_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module rcl_prescaler
   import rcl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic secondary_crystal_osc_in,
   input wire logic internal_low_power_osc_in,
   input wire logic line_in,
   rcl_tick_if.prescaler tk
);

   rcl_pre_type s_ff;
   rcl_pre_type nxt_s;
   logic [1:0] src_idx;

   // Both line frequencies arrive on the same pin.
   assign src_idx = tk.csel[1] ? 2'h2 : {1'b0, tk.csel[0]};

   always_comb
   begin
      logic [15:0] term;
      logic now_lvl;
      logic old_lvl;
      term = HALF_SECONDARY_CRYSTAL_OSC;
      now_lvl = s_ff.sync2[src_idx];
      old_lvl = s_ff.prev[src_idx];
      nxt_s = s_ff;
      nxt_s.sync1 = {line_in, internal_low_power_osc_in, secondary_crystal_osc_in};
      nxt_s.sync2 = s_ff.sync1;
      nxt_s.prev = s_ff.sync2;
      nxt_s.half_pulse = 1'b0;
      nxt_s.src_edge = now_lvl & ~old_lvl;
      unique case (tk.csel) // R9 R10
         CSEL_SECONDARY_CRYSTAL_OSC: term = HALF_SECONDARY_CRYSTAL_OSC;
         CSEL_INTERNAL_LOW_POWER_OSC: term = HALF_INTERNAL_LOW_POWER_OSC;
         CSEL_50HZ: term = HALF_50HZ;
         CSEL_60HZ: term = HALF_60HZ;
      endcase
      // Positive trim adds source pulses, so the half second ends sooner.
      if (s_ff.cal_cnt == 5'h00 && !tk.csel[1])
      begin
         term = term - {{8{tk.cal[7]}}, tk.cal}; // R18 R19 R21
      end
      if (!tk.enable || tk.resync)
      begin
         nxt_s.cnt = 16'h0000;
         nxt_s.halfsec = 1'b0;
         nxt_s.cal_cnt = 5'h00;
      end
      else if (now_lvl && !old_lvl)
      begin
         if (s_ff.cnt >= term - 16'h0001)
         begin
            nxt_s.cnt = 16'h0000;
            nxt_s.half_pulse = 1'b1;
            nxt_s.halfsec = ~s_ff.halfsec; // R12
            if (s_ff.cal_cnt == CAL_HALVES - 5'h01)
            begin
               nxt_s.cal_cnt = 5'h00; // R18
            end
            else
            begin
               nxt_s.cal_cnt = s_ff.cal_cnt + 5'h01;
            end
         end
         else
         begin
            nxt_s.cnt = s_ff.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign tk.half_pulse = s_ff.half_pulse;
   assign tk.halfsec = s_ff.halfsec;
   assign tk.src_level = s_ff.prev[src_idx];
   assign tk.src_edge = s_ff.src_edge;

endmodule
`default_nettype wire

// >>> rcl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rcl_properties(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic rtc_out,
   input wire logic rtc_out_en,
   input wire logic alarm_pulse_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_acc;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   property p_ans; s_req |=> s_acc; endproperty
   property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
   property p_hi; !avs_waitrequest |-> avs_readdata[31:16] == 16'h0;
   endproperty
   property p_unmap;
      avs_read && avs_address > 3'h4 && !avs_waitrequest
         |-> avs_readdata == 32'h0;
   endproperty
   property p_hold; !avs_waitrequest |=> $stable(avs_readdata); endproperty
   property p_load; !$stable(avs_readdata) |-> !avs_waitrequest; endproperty
   property p_oe; !rtc_out_en |-> !rtc_out; endproperty
   property p_pulse; alarm_pulse_out |=> !alarm_pulse_out; endproperty
   a_ans: assert property (p_ans)
      else $error("request not accepted after one wait cycle");
   a_idle: assert property (p_idle) else $error("accept without request");
   a_hi: assert property (p_hi)
      else $error("upper read data not zero");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_hold: assert property (p_hold) else $error("read data changed");
   a_load: assert property (p_load) else $error("read data off accept");
   a_oe: assert property (p_oe)
      else $error("output driven while disabled");
   a_pulse: assert property (p_pulse)
      else $error("alarm pulse longer than one cycle");
endmodule
bind rcl_calendar_block rcl_properties u_prop(.ref_clk(ref_clk),
   .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .rtc_out(rtc_out),
   .rtc_out_en(rtc_out_en), .alarm_pulse_out(alarm_pulse_out));
`default_nettype wire

// >>> calendar_clock_alarm_windows_test.sv
`timescale 1ns/1ps
`default_nettype none
module calendar_clock_alarm_windows_test;
   import rcl_pkg::*;
   logic ref_clk = 0, rstn = 0, rd = 0, wr = 0, line = 0, wq, ro, roe;
   logic pwr, alm;
   logic [1:0] dv = 0;
   logic [2:0] adr = 0;
   logic [3:0] be = 4'h3;
   logic [31:0] wd = 0, rdata;
   logic [15:0] d;
   int n_fail = 0, compares = 0, npul = 0, np = 0, n0, n;
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      dv <= dv + 2'h1;
      line <= line ^ (dv == 2'h3);
      if (alm)
         npul <= npul + 1;
      if (pwr)
         np <= np + 1;
   end
   rcl_calendar_block dut(.ref_clk(ref_clk), .rstn(rstn),
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(wq), .secondary_crystal_osc_in(1'b0), .internal_low_power_osc_in(1'b0),
      .line_in(line), .rtc_out(ro), .rtc_out_en(roe),
      .pwr_ctl_out(pwr), .alarm_pulse_out(alm));
   task automatic chk(input string nm, input logic [15:0] s, e);
      compares++;
      if (s !== e)
      begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic acc(input logic [2:0] a, input logic w,
      input logic [15:0] v);
      @(posedge ref_clk);
      adr <= a;
      wd <= {16'h0, v};
      wr <= w;
      rd <= !w;
      do
      begin
         @(posedge ref_clk);
      end
      while (wq !== 1'b0);
      d = rdata[15:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic win(input logic [2:0] c, input logic [15:0] cv,
      input logic [2:0] x, input logic w, input logic [15:0] v [4]);
      acc(c, 1, cv);
      for (int i = 0; i < 4; i++)
      begin
         acc(x, w, v[i]);
         if (!w)
            chk("window", d, v[i]);
      end
   endtask
   task automatic results;
      if (n_fail == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic alarm(input logic [15:0] cv);
      acc(IDX_ALCFG, 1, cv);
      n0 = npul;
      repeat (HALF_50HZ * 56) @(posedge ref_clk);
      n = npul - n0;
      acc(IDX_ALCFG, 0, 16'h0);
   endtask
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      results;
   end
   initial
   begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      chk("power", {15'h0, pwr}, 16'h1);
      acc(IDX_CFG, 1, 16'h2300);
      acc(IDX_TVAL, 1, 16'h0012);
      acc(IDX_CFG, 0, 16'h0);
      chk("lock", d, 16'h0300);
      acc(IDX_KEY, 1, 16'h0055);
      acc(IDX_KEY, 1, 16'h00AA);
      acc(IDX_CFG, 1, 16'h2300);
      acc(IDX_CFG, 1, 16'hA300);
      acc(IDX_PWC, 1, 16'h0800);
      win(IDX_CFG, 16'hA300, IDX_TVAL, 1,
         '{16'h0024, 16'h1231, 16'h0623, 16'h5959});
      acc(IDX_CFG, 1, 16'h8300);
      win(IDX_ALCFG, 16'h0300, IDX_AVAL, 1,
         '{16'h0A0B, 16'h1231, 16'h0623, 16'h0000});
      win(IDX_CFG, 16'hA300, IDX_TVAL, 0,
         '{16'h0024, 16'h1231, 16'h0623, 16'h5959});
      win(IDX_ALCFG, 16'h0300, IDX_AVAL, 0,
         '{16'h0A0B, 16'h1231, 16'h0623, 16'h0000});
      repeat (HALF_50HZ * 24) @(posedge ref_clk);
      win(IDX_CFG, 16'hA300, IDX_TVAL, 0,
         '{16'h0025, 16'h0101, 16'h0000, 16'h0000});
      for (int i = 5; i < 8; i++)
      begin
         acc(3'(i), 0, 16'h0);
         chk("unmapped", d, 16'h0);
      end
      alarm(16'h8401);
      chk("pulses", 16'(n), 16'h2);
      chk("alcfg", d, 16'h0400);
      alarm(16'hC400);
      chk("chime", 16'(n > 2), 16'h1);
      chk("repeat", d, 16'hC400 | 16'((256 - n) & 255));
      acc(IDX_PWC, 1, 16'hC900);
      acc(IDX_CFG, 1, 16'hA700);
      acc(IDX_ALCFG, 1, 16'h8000);
      n0 = np;
      repeat (HALF_50HZ * 24) @(posedge ref_clk);
      acc(IDX_CFG, 0, 16'h0);
      chk("cfg", d & 16'hE7FF, 16'h8700);
      chk("out", {14'h0, roe, ro}, {14'h0, 1'b1, d[11]});
      chk("pwc", 16'(np - n0 > 170 && np - n0 < 190), 16'h1);
      results;
   end
endmodule
`default_nettype wire
